// File: src/iddrv_core.sv
// Purpose: serial control and diagnostic port of a five-gate isolator
// Assumes: sck idles high when chip_select_n moves; host keeps timing
// Notes:   link logic on sck, control logic on clk
// What this block does
// - frames are 32 bits, msb first
// - input bits sampled on rising sck
// - idle select ignores sck and data
// - output released while select high
// - reply status or previously selected register
// - read reply only after correct chip id
// - output changes after falling sck
// - select low wakes, ready within 100 us
// - phase gates on by command until off/fault
// - two supply gates individually controlled
// - bridge undervoltage flags, optional auto-off
// - overcurrent flags, optional auto-off
// - overcurrent thresholds written serially
// - filtered supply/gate undervoltage latches fault
// - link charging pulses via overcurrent path
// - watchdog supervises host traffic
// - fault_indicator_output pin: fault flag or clock
// - pump disable drops gates, flags undervoltage
`timescale 1ns/1ps
`default_nettype none
module iddrv_core
   import iddrv_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int WDOG_CYCLES = WDOG_CYC
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             sck,
   input  wire logic             chip_select_n,
   input  wire logic             mosi,
   output var  logic             miso_o,
   output var  logic             miso_oe_n,
   input  wire logic             bridge_positive_undervoltage,
   input  wire logic             bridge_negative_undervoltage,
   input  wire logic             positive_overcurrent,
   input  wire logic             negative_overcurrent,
   input  wire logic             pumped_supply_low,
   input  wire logic             gate_drive_low,
   output var  logic             phase_a_gate,
   output var  logic             phase_b_gate,
   output var  logic             phase_c_gate,
   output var  logic             reverse_protect_gate,
   output var  logic             bridge_supply_gate,
   output var  logic             pump_enable,
   output var  logic [THR_W-1:0] oc_pos_threshold,
   output var  logic [THR_W-1:0] oc_neg_threshold,
   output var  logic             fault_indicator_output,
   output var  logic             awake
);
   localparam int WKW = $clog2(WAKE_CYCLES + 1);
   localparam int WDW = $clog2(WDOG_CYCLES + 1);
   localparam logic [WKW-1:0] WAKE_END = WKW'(WAKE_CYCLES);
   localparam logic [WDW-1:0] WDOG_END = WDW'(WDOG_CYCLES);
   localparam logic [15:0] TICK_END = 16'(CHG_TICK_CYC - 1);

   // ---------------- link domain (sck) ----------------
   logic [5:0]         rcnt_r;   // rising edges this frame, saturates
   logic [5:0]         fcnt_r;   // falling edges this frame, saturates
   logic [FRAME_W-1:0] rx_r;
   logic               good_tog_r;
   logic               bad_tog_r;
   logic [FRAME_W-1:0] tx_word_r; // clk domain, stable while selected

   // edge counter cleared by the idle select itself
   always_ff @(posedge sck or posedge chip_select_n) begin
      if (chip_select_n)
         rcnt_r <= '0;
      else if (rcnt_r != BITS_OK + 6'h01)
         rcnt_r <= rcnt_r + 6'h01;
   end

   // shift in on rising edge; toggles mark 32nd and the first extra (33rd) edge
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         rx_r       <= '0;
         good_tog_r <= 1'b0;
         bad_tog_r  <= 1'b0;
      end else if (!chip_select_n) begin
         rx_r <= {rx_r[FRAME_W-2:0], mosi};
         if (rcnt_r == BITS_OK - 6'h01)
            good_tog_r <= ~good_tog_r;
         if (rcnt_r == BITS_OK)
            bad_tog_r <= ~bad_tog_r;
      end
   end

   // the first fall keeps the msb; later falls advance
   always_ff @(negedge sck or posedge chip_select_n) begin
      if (chip_select_n)
         fcnt_r <= '0;
      else if (|rcnt_r && fcnt_r != BITS_OK)
         fcnt_r <= fcnt_r + 6'h01;
   end

   // msb is presented as soon as select falls
   always_comb begin
      if (fcnt_r >= BITS_OK)
         miso_o = 1'b0;
      else
         miso_o = tx_word_r[5'd31 - fcnt_r[4:0]];
   end
   assign miso_oe_n = chip_select_n;

   // ---------------- control domain (clk) ----------------
   logic cs_m_r, cs_s_r, cs_d_r;
   logic gd_m_r, gd_s_r, gd_seen_r;
   logic bd_m_r, bd_s_r, bd_seen_r;
   logic frame_end, frame_ok, id_ok, wr_en, rd_req;
   logic [2:0]        addr;
   logic [DATA_W-1:0] wdata;

   // synchronisers for select and the frame toggles
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         gd_m_r <= 1'b0;
         gd_s_r <= 1'b0;
         bd_m_r <= 1'b0;
         bd_s_r <= 1'b0;
      end else if (ce) begin
         cs_m_r <= chip_select_n;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         gd_m_r <= good_tog_r;
         gd_s_r <= gd_m_r;
         bd_m_r <= bad_tog_r;
         bd_s_r <= bd_m_r;
      end
   end

   // select rise has the same two-flop depth as the toggles; they settle first only because they change earlier
   assign frame_end = cs_s_r & ~cs_d_r & ce;
   assign frame_ok  = (gd_s_r != gd_seen_r) && (bd_s_r == bd_seen_r);
   assign id_ok     = rx_r[ID_MSB:ID_LSB] == CHIP_ID;
   assign rd_req    = rx_r[RD_BIT];
   assign addr      = rx_r[ADDR_MSB:ADDR_LSB];
   assign wdata     = rx_r[DATA_W-1:0];
   assign wr_en     = frame_end & frame_ok & id_ok & ~rd_req;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gd_seen_r <= 1'b0;
         bd_seen_r <= 1'b0;
      end else if (frame_end) begin
         gd_seen_r <= gd_s_r;
         bd_seen_r <= bd_s_r;
      end
   end

   // configuration registers
   logic [DATA_W-1:0] ctrl_r, fcfg_r, thr_r, chg_r;
   logic              sleep_r;
   logic [NFLAG-1:0]  flags_r, flag_set, flag_clr;

   // writes land only from whole frames with the right id
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         fcfg_r <= FCFG_RST;
         thr_r  <= THR_RST;
         chg_r  <= CHG_RST;
      end else if (wr_en) begin
         case (addr)
            ADDR_CTRL: ctrl_r <= wdata & ~(24'h000001 << CTRL_SLEEP);
            ADDR_FCFG: fcfg_r <= wdata;
            ADDR_THR:  thr_r  <= wdata;
            ADDR_CHG:  chg_r  <= wdata;
            default:   ;
         endcase
      end
   end

   // read selection remembered for the next frame
   logic       rd_pend_r, id_bad_r;
   logic [2:0] rd_addr_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pend_r <= 1'b0;
         rd_addr_r <= '0;
         id_bad_r  <= 1'b0;
      end else if (frame_end && frame_ok) begin
         rd_pend_r <= rd_req & id_ok;
         rd_addr_r <= addr;
         id_bad_r  <= ~id_ok;
      end
   end

   // sleep entry by command, wake on select low then timed recovery
   logic [WKW-1:0] wake_cnt_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_r    <= 1'b0;
         wake_cnt_r <= WAKE_END;
      end else if (ce) begin
         if (wr_en && addr == ADDR_CTRL && wdata[CTRL_SLEEP])
            sleep_r <= 1'b1;
         else if (sleep_r && !cs_s_r) begin
            sleep_r    <= 1'b0;
            wake_cnt_r <= '0;
         end else if (!sleep_r && wake_cnt_r != WAKE_END)
            wake_cnt_r <= wake_cnt_r + 1'b1;
      end
   end
   assign awake = ~sleep_r & (wake_cnt_r == WAKE_END);

   // filtered monitors: uvp, uvn, ocp, ocn, pump low, gate low
   logic [NMON-1:0] mon_raw, mon_hit, mon_q_r;
   assign mon_raw = {gate_drive_low, pumped_supply_low,
                     negative_overcurrent, positive_overcurrent,
                     bridge_negative_undervoltage,
                     bridge_positive_undervoltage};
   genvar gi;
   generate
      for (gi = 0; gi < NMON; gi++) begin : g_mon
         iddrv_filt #(
            .FILT (gi < 2 ? BRG_FILT_CYC :
                   gi < 4 ? OC_FILT_CYC : UV_FILT_CYC)
         ) u_filt (
            .clk   (clk),
            .rst_n (rst_n),
            .ce    (ce),
            .raw   (mon_raw[gi]),
            .hit   (mon_hit[gi])
         );
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         mon_q_r <= '0;
      else if (ce)
         mon_q_r <= mon_hit;
   end

   // watchdog restarts on every accepted frame
   logic [WDW-1:0] wd_cnt_r;
   logic           wd_evt;
   assign wd_evt = ctrl_r[CTRL_WDOG] && (wd_cnt_r == WDOG_END);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         wd_cnt_r <= '0;
      else if (ce) begin
         if (!ctrl_r[CTRL_WDOG] || (frame_end && frame_ok))
            wd_cnt_r <= '0;
         else if (!wd_evt)
            wd_cnt_r <= wd_cnt_r + 1'b1;
      end
   end

   // gate requests and the loss of pump voltage
   logic [NGATE-1:0] gate_req, gate_on;
   logic             charge_mode, pump_on, kill, chg_hold;
   logic [3:0]       auto_cfg;
   assign gate_req    = ctrl_r[CTRL_GATE_LSB +: NGATE];
   assign charge_mode = fcfg_r[FCFG_CHARGE];
   assign pump_on     = ctrl_r[CTRL_PUMP] & awake;
   assign pump_enable = pump_on;

   // in charge mode positive overcurrent pulses the bridge gate, no latch-off
   assign auto_cfg = fcfg_r[3:0] & ~({3'h0, charge_mode} << FL_OCP);

   // flag events: rising filtered levels, pump-off with gates asked, watchdog expiry, wrong-id frames
   always_comb begin
      flag_set          = '0;
      flag_set[3:0]     = mon_hit[3:0] & ~mon_q_r[3:0];
      flag_set[FL_PUMP] = mon_hit[4] & ~mon_q_r[4];
      flag_set[FL_GATE] = (mon_hit[5] & ~mon_q_r[5])
                        | (~pump_on & awake & |gate_req);
      flag_set[FL_WDOG] = wd_evt;
      flag_set[FL_ID]   = frame_end & frame_ok & ~id_ok;
   end
   assign flag_clr = (wr_en && addr == ADDR_STAT) ? wdata[NFLAG-1:0] : '0;

   // sticky flags; a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         flags_r <= '0;
      else if (ce)
         flags_r <= (flags_r & ~flag_clr) | flag_set;
   end

   // shutdown uses the event itself so gates drop with the latch
   assign kill = |((flags_r[3:0] | flag_set[3:0]) & auto_cfg)
               | flags_r[FL_WDOG] | wd_evt;

   // charging pause: bridge gate off for rate ticks after each trip
   logic [RATE_W-1:0] chg_cnt_r;
   logic [15:0]       tick_r;
   assign chg_hold = chg_cnt_r != '0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chg_cnt_r <= '0;
         tick_r    <= '0;
      end else if (ce) begin
         if (charge_mode && flag_set[FL_OCP]) begin
            chg_cnt_r <= chg_r[RATE_LSB +: RATE_W];
            tick_r    <= '0;
         end else if (chg_hold) begin
            tick_r <= (tick_r == TICK_END) ? 16'h0000 : tick_r + 16'h0001;
            if (tick_r == TICK_END)
               chg_cnt_r <= chg_cnt_r - 1'b1;
         end
      end
   end

   // every drive needs pump voltage and no active shutdown
   always_comb begin
      gate_on = gate_req & {NGATE{pump_on & ~kill}};
      if (chg_hold || (charge_mode && mon_hit[2]))
         gate_on[4] = 1'b0;
   end
   assign phase_a_gate         = gate_on[0];
   assign phase_b_gate         = gate_on[1];
   assign phase_c_gate         = gate_on[2];
   assign reverse_protect_gate = gate_on[3];
   assign bridge_supply_gate   = gate_on[4];

   // charging magnitude replaces the positive threshold while charging
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oc_pos_threshold <= THR_RST[OCP_LSB +: THR_W];
         oc_neg_threshold <= THR_RST[OCN_LSB +: THR_W];
      end else if (ce) begin
         oc_pos_threshold <= charge_mode ? chg_r[MAG_LSB +: THR_W]
                                         : thr_r[OCP_LSB +: THR_W];
         oc_neg_threshold <= thr_r[OCN_LSB +: THR_W];
      end
   end

   // fault_indicator_output pin: any flag, or core clock divided by two
   logic clk_div_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_div_r              <= 1'b0;
         fault_indicator_output <= 1'b0;
      end else if (ce) begin
         clk_div_r              <= ~clk_div_r;
         fault_indicator_output <= ctrl_r[CTRL_DIAGCLK] ? clk_div_r
                                                        : |flags_r;
      end
   end

   // reply word; only refreshed while select is idle, host lead time
   // covers the synchroniser delay after select falls
   logic [DATA_W-1:0] status_w, reply;
   assign status_w = {10'h000, awake, gate_on, flags_r};
   always_comb begin
      case (rd_pend_r ? rd_addr_r : ADDR_STAT)
         ADDR_CTRL: reply = ctrl_r;
         ADDR_FCFG: reply = fcfg_r;
         ADDR_THR:  reply = thr_r;
         ADDR_CHG:  reply = chg_r;
         default:   reply = status_w;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         tx_word_r <= {CHIP_ID, 4'h0, 24'h000000};
      else if (ce && cs_s_r && cs_d_r)
         tx_word_r <= {CHIP_ID, 3'h0, id_bad_r, reply};
   end
endmodule : iddrv_core
`default_nettype wire

// File: src/iddrv_pkg.sv
// Purpose: shared constants of the isolator driver serial control block
// Assumes: 50 MHz core clock, 32-bit serial frames
// Notes:   frame = id[31:28] read[27] addr[26:24] data[23:0]
package iddrv_pkg;
   // frame layout
   localparam int FRAME_W  = 32;
   localparam int DATA_W   = 24;
   localparam int ID_MSB   = 31;
   localparam int ID_LSB   = 28;
   localparam int RD_BIT   = 27;
   localparam int ADDR_MSB = 26;
   localparam int ADDR_LSB = 24;
   localparam logic [3:0] CHIP_ID = 4'h5; // arbitrary value
   localparam logic [5:0] BITS_OK = 6'h20; // rising edges in a good frame

   // register addresses
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_FCFG = 3'h1;
   localparam logic [2:0] ADDR_THR  = 3'h2;
   localparam logic [2:0] ADDR_CHG  = 3'h3;
   localparam logic [2:0] ADDR_STAT = 3'h4;

   // control fields: gates a,b,c,reverse,bridge in [4:0]
   localparam int CTRL_GATE_LSB = 0;
   localparam int NGATE         = 5;
   localparam int CTRL_PUMP     = 5;
   localparam int CTRL_DIAGCLK  = 6;
   localparam int CTRL_WDOG     = 7;
   localparam int CTRL_SLEEP    = 8;
   localparam logic [23:0] CTRL_RST = 24'h000020;

   // fault config: auto-off enables for uvp,uvn,ocp,ocn, then charge mode
   localparam int FCFG_CHARGE = 4;
   localparam logic [23:0] FCFG_RST = 24'h00000f;

   // thresholds and charging
   localparam int THR_W   = 7;
   localparam int OCP_LSB = 0;
   localparam int OCN_LSB = 8;
   localparam logic [23:0] THR_RST = 24'h003f3f;
   localparam int MAG_LSB  = 0;
   localparam int RATE_LSB = 8;
   localparam int RATE_W   = 8;
   localparam logic [23:0] CHG_RST = 24'h000811;

   // status flags
   localparam int FL_UVP  = 0;
   localparam int FL_UVN  = 1;
   localparam int FL_OCP  = 2;
   localparam int FL_OCN  = 3;
   localparam int FL_PUMP = 4;
   localparam int FL_GATE = 5;
   localparam int FL_WDOG = 6;
   localparam int FL_ID   = 7;
   localparam int NFLAG   = 8;
   localparam int NMON    = 6; // filtered monitor inputs

   // timing
   localparam int CLK_MHZ      = 50;
   localparam int BRG_FILT_NS  = 1000;
   localparam int BRG_FILT_CYC = (BRG_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int UV_FILT_NS   = 2000;
   localparam int UV_FILT_CYC  = (UV_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int OC_FILT_CYC  = 1;
   localparam int WAKE_US      = 100;
   localparam int WAKE_CYC     = WAKE_US * CLK_MHZ;
   localparam int WDOG_MS      = 10;
   localparam int WDOG_CYC     = WDOG_MS * 1000 * CLK_MHZ;
   localparam int CHG_TICK_NS  = 1000;
   localparam int CHG_TICK_CYC = (CHG_TICK_NS * CLK_MHZ) / 1000;
endpackage : iddrv_pkg

// File: src/iddrv_filt.sv
// Purpose: synchronise one comparator level and require it to persist
// Assumes: raw input is asynchronous to clk
// Notes:   hit is a registered level, high while the condition persists
`timescale 1ns/1ps
`default_nettype none
module iddrv_filt #(
   parameter int FILT = 1
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic raw,
   output var  logic hit
);
   localparam int CW = $clog2(FILT + 1);
   localparam logic [CW-1:0] LIMIT = CW'(FILT);

   logic          meta_r;
   logic          sync_r;
   logic [CW-1:0] cnt_r;

   // two-flop synchroniser, first flop feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else if (ce) begin
         meta_r <= raw;
         sync_r <= meta_r;
      end
   end

   // persistence count; hit needs FILT high samples in a row, so a one-sample glitch passes only when FILT is 1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         hit   <= 1'b0;
      end else if (ce) begin
         if (!sync_r) begin
            cnt_r <= '0;
            hit   <= 1'b0;
         end else if (cnt_r != LIMIT) begin
            cnt_r <= cnt_r + 1'b1;
            hit   <= (cnt_r == LIMIT - 1'b1);
         end
      end
   end
endmodule : iddrv_filt
`default_nettype wire

// File: sim/iddrv_host_model.sv
// Purpose: host controller model driving the serial link
// Assumes: sck idles high and only moves inside a frame
// Notes:   miso taken at each rising sck; done fires on whole frames
`timescale 1ns/1ps
`default_nettype none
module iddrv_host_model (
   output var logic  sck,
   output var logic  chip_select_n,
   output var logic  mosi,
   input  wire logic miso_o,
   input  wire logic miso_oe_n
);
   logic [31:0] reply;
   event        done;

   // idle link one step in, so the link flops see a reset edge
   initial begin
      #1;
      sck = 1'b1;
      chip_select_n = 1'b1;
      mosi = 1'b0;
      reply = 32'h0;
   end

   // a released miso reads as the last bit inverted
   task automatic send(input logic [31:0] w, input int nb);
      chip_select_n = 1'b0;
      #1000;
      for (int i = 0; i < nb; i++) begin
         sck = 1'b0;
         mosi = w[31-i];
         #6;
         sck = 1'b1;
         reply = {reply[30:0], miso_oe_n ? ~reply[0] : miso_o};
         #6;
      end
      #30;
      chip_select_n = 1'b1;
      mosi = 1'b0;
      if (nb == 32) -> done;
      #1320;
   endtask : send
endmodule : iddrv_host_model
`default_nettype wire

// File: sim/iddrv_core_assertions.sv
// Purpose: concurrent checks on the serial control block's ports
// Assumes: fault auto-off kept at reset setting, charge mode unused
// Notes:   bound into every core instance
`timescale 1ns/1ps
`default_nettype none
module iddrv_core_assertions
   import iddrv_pkg::*;
#(
   parameter int WAKE_CYCLES = WAKE_CYC,
   parameter int WDOG_CYCLES = WDOG_CYC
) (
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             chip_select_n,
   input wire logic             miso_oe_n,
   input wire logic             positive_overcurrent,
   input wire logic             bridge_positive_undervoltage,
   input wire logic             phase_a_gate,
   input wire logic             phase_b_gate,
   input wire logic             phase_c_gate,
   input wire logic             reverse_protect_gate,
   input wire logic             bridge_supply_gate,
   input wire logic             pump_enable,
   input wire logic [THR_W-1:0] oc_pos_threshold,
   input wire logic [THR_W-1:0] oc_neg_threshold,
   input wire logic             awake
);
   wire logic [4:0] gates;
   logic [7:0]      cs_cnt;
   logic [7:0]      uv_cnt;
   logic            woke_r;
   int              slp_cnt;

   // all five drives as one vector
   assign gates = {bridge_supply_gate, reverse_protect_gate, phase_c_gate,
                   phase_b_gate, phase_a_gate};

   // cycles since select rose
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cs_cnt <= 8'h0;
      else if (!chip_select_n) cs_cnt <= 8'h0;
      else if (cs_cnt != 8'hff) cs_cnt <= cs_cnt + 8'h1;
   end

   // length of the current positive bridge undervoltage, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) uv_cnt <= 8'h0;
      else if (!bridge_positive_undervoltage) uv_cnt <= 8'h0;
      else if (uv_cnt != 8'hff) uv_cnt <= uv_cnt + 8'h1;
   end

   // wake time: counted from select low while asleep until awake
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         woke_r <= 1'b0;
         slp_cnt <= 0;
      end else if (awake) begin
         woke_r <= 1'b0;
         slp_cnt <= 0;
      end else begin
         if (!chip_select_n) woke_r <= 1'b1;
         if (woke_r) slp_cnt <= slp_cnt + 1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   AST_OE_SELECT: assert property (miso_oe_n == chip_select_n)
      else $error("miso enable does not follow select");
   AST_OCP_OFF: assert property (
      positive_overcurrent [*6] |-> gates == 5'h0)
      else $error("gates on during overcurrent");
   AST_UVP_OFF: assert property (uv_cnt == 8'd60 |-> gates == 5'h0)
      else $error("gates on during bridge undervoltage");
   AST_SLEEP_PUMP: assert property (!awake |-> !pump_enable)
      else $error("pump on while asleep");
   AST_WAKE_BOUND: assert property (slp_cnt <= WAKE_CYCLES + 8)
      else $error("wake took too long");
   AST_THR_WRITE: assert property (
      !$stable({oc_pos_threshold, oc_neg_threshold}) |-> cs_cnt inside {[2:10]})
      else $error("threshold moved outside a frame end");
   AST_GATE_ON_FRAME: assert property (
      |(gates & ~$past(gates)) |-> cs_cnt inside {[2:10]})
      else $error("gate turned on without a command");
   AST_SELECT_QUIET: assert property (
      $fell(chip_select_n) |-> $stable(oc_neg_threshold) [*8])
      else $error("threshold moved while selected");

   cover property (positive_overcurrent [*6]);
   cover property (slp_cnt == 5);
   cover property (!$stable(oc_pos_threshold));
endmodule : iddrv_core_assertions

bind iddrv_core iddrv_core_assertions #(
   .WAKE_CYCLES(WAKE_CYCLES),
   .WDOG_CYCLES(WDOG_CYCLES)
) iddrv_core_assertions_i (
   .clk, .rst_n, .chip_select_n, .miso_oe_n, .positive_overcurrent,
   .bridge_positive_undervoltage, .phase_a_gate, .phase_b_gate,
   .phase_c_gate, .reverse_protect_gate, .bridge_supply_gate,
   .pump_enable, .oc_pos_threshold, .oc_neg_threshold, .awake
);
`default_nettype wire

// File: sim/iddrv_core_tb_top.sv
// Purpose: self-checking bench for the isolator serial control block
// Assumes: host model drives the link; faults change at falling clk
// Notes:   expected replies queued, checked by a separate monitor
`timescale 1ns/1ps
`default_nettype none
module iddrv_core_tb_top
   import iddrv_pkg::*;
();
   localparam logic [31:0] MSK = 32'hf9ffffff; // reply bits 26:25 open
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   logic             ce = 1'b1;
   logic             bridge_positive_undervoltage = 1'b0;
   logic             bridge_negative_undervoltage = 1'b0;
   logic             positive_overcurrent = 1'b0;
   logic             negative_overcurrent = 1'b0;
   logic             pumped_supply_low = 1'b0;
   logic             gate_drive_low = 1'b0;
   logic             sck, chip_select_n, mosi, miso_o, miso_oe_n;
   logic             phase_a_gate, phase_b_gate, phase_c_gate;
   logic             reverse_protect_gate, bridge_supply_gate, pump_enable;
   logic             fault_indicator_output, awake, tq;
   logic [THR_W-1:0] oc_pos_threshold, oc_neg_threshold, tp, tn;
   logic [4:0]       g = 5'h0; // gates the bench has asked for
   logic [4:0]       gv;
   logic [31:0]      e;
   logic [31:0]      expq[$];
   logic [7:0]       fl[3] = '{8'h04, 8'h01, 8'h20};
   int               err_count = 0;
   int               n_tests = 0;
   int               seed = 32'ha256;

   assign gv = {bridge_supply_gate, reverse_protect_gate, phase_c_gate,
                phase_b_gate, phase_a_gate};

   always #10 clk = ~clk;

   // short counts keep the sleep and watchdog runs brief
   iddrv_core #(.WAKE_CYCLES(20), .WDOG_CYCLES(200)) iddrv_core_i (
      .clk, .rst_n, .ce, .sck, .chip_select_n, .mosi, .miso_o, .miso_oe_n,
      .bridge_positive_undervoltage, .bridge_negative_undervoltage,
      .positive_overcurrent, .negative_overcurrent, .pumped_supply_low,
      .gate_drive_low, .phase_a_gate, .phase_b_gate, .phase_c_gate,
      .reverse_protect_gate, .bridge_supply_gate, .pump_enable,
      .oc_pos_threshold, .oc_neg_threshold, .fault_indicator_output, .awake
   );

   iddrv_host_model iddrv_host_model_i (
      .sck, .chip_select_n, .mosi, .miso_o, .miso_oe_n
   );

   // one counted comparison; an unknown matches only an unknown
   task automatic chk_lvl(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_lvl

   // oldest note against the reply word just received
   task automatic chk_reply(input logic [31:0] got);
      logic [31:0] x;
      x = expq.pop_front();
      chk_lvl(got & MSK, x & MSK);
   endtask : chk_reply

   always @(iddrv_host_model_i.done) chk_reply(iddrv_host_model_i.reply);

   function automatic logic [31:0] st(input logic [7:0] f, input logic b,
                                      input logic [4:0] gs);
      return {CHIP_ID, 3'h0, b, 10'h0, 1'b1, gs, f};
   endfunction : st

   function automatic logic [31:0] fr(input logic r, input logic [2:0] a,
                                      input logic [23:0] d);
      return {CHIP_ID, r, a, d};
   endfunction : fr

   // short frames are refused: no reply is expected
   task automatic xfer(input logic [31:0] w, input logic [31:0] x,
                       input int nb);
      if (nb == 32) expq.push_back(x);
      iddrv_host_model_i.send(w, nb);
   endtask : xfer

   // hold one fault input for n cycles, then release it
   task automatic fault(input int k, input int n);
      @(negedge clk);
      if (k == 0) positive_overcurrent = 1'b1;
      else if (k == 1) bridge_positive_undervoltage = 1'b1;
      else gate_drive_low = 1'b1;
      repeat (n) @(negedge clk);
      chk_lvl({fault_indicator_output, gv}, {1'b1, k < 2 ? 5'h0 : g});
      positive_overcurrent = 1'b0;
      bridge_positive_undervoltage = 1'b0;
      gate_drive_low = 1'b0;
   endtask : fault

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // main sequence
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      chk_lvl({gv, pump_enable, fault_indicator_output, miso_oe_n, awake,
               oc_pos_threshold, oc_neg_threshold},
              {5'h0, 4'b1011, 7'h3f, 7'h3f});
      tp = 7'($random(seed));
      tn = 7'($random(seed));
      xfer(fr(1'b0, ADDR_THR, {9'h0, tn, 1'b0, tp}), st(8'h0, 1'b0, g), 32);
      chk_lvl({oc_pos_threshold, oc_neg_threshold}, {tp, tn});
      xfer(fr(1'b1, ADDR_THR, 24'h0), st(8'h0, 1'b0, g), 32);
      e = {CHIP_ID, 4'h0, 9'h0, tn, 1'b0, tp};
      xfer(fr(1'b0, ADDR_STAT, 24'h0), e, 32);
      for (int i = 0; i < 4; i++) begin
         e = st(8'h0, 1'b0, g);
         g = (i == 3) ? 5'h1f : 5'($random(seed));
         xfer(fr(1'b0, ADDR_CTRL, {18'h0, 1'b1, g}), e, 32);
         chk_lvl(gv, g);
      end
      xfer(fr(1'b0, ADDR_CTRL, 24'h20), 32'h0, 31);
      chk_lvl(gv, g);
      xfer({4'ha, 1'b1, ADDR_THR, 24'h0}, st(8'h0, 1'b0, g), 32);
      xfer(fr(1'b0, ADDR_STAT, 24'h0), st(8'h80, 1'b1, g), 32);
      xfer(fr(1'b0, ADDR_STAT, 24'hff), st(8'h80, 1'b0, g), 32);
      for (int k = 0; k < 3; k++) begin
         fault(k, (k == 0) ? 8 : 120);
         e = st(fl[k], 1'b0, k < 2 ? 5'h0 : g);
         xfer(fr(1'b0, ADDR_STAT, 24'hff), e, 32);
         chk_lvl({fault_indicator_output, gv}, {1'b0, g});
      end
      xfer(fr(1'b0, ADDR_CTRL, {16'h0, 3'b111, g}), st(8'h0, 1'b0, g), 32);
      @(negedge clk) tq = fault_indicator_output;
      @(negedge clk) chk_lvl(fault_indicator_output, !tq);
      repeat (160) @(negedge clk); // silence trips the watchdog
      xfer(fr(1'b0, ADDR_CTRL, 24'h100), st(8'h40, '0, '0), 32);
      chk_lvl({awake, pump_enable, gv}, 7'h0);
      xfer(32'h0, 32'h0, 31);
      chk_lvl(awake, 1'b1);
      final_report();
   end

   // hang guard, well beyond the sequence
   initial begin
      #400000;
      err_count++;
      final_report();
   end
endmodule : iddrv_core_tb_top
`default_nettype wire
